// File: bench/board_model.sv
// board-side pad model: resolves each pad from device drive, pull-up and external source
`timescale 1ns/1ps
module board_model #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] padOut,
  input  wire logic [W-1:0] padOe,
  input  wire logic [W-1:0] pullEn,
  input  wire logic [W-1:0] extEn,
  input  wire logic [W-1:0] extVal,
  output logic      [W-1:0] padIn
);
  logic [W-1:0] noise = '0;
  // a floating pad must not look stable to the sampler
  always @(posedge clk) noise <= ~noise;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (padOe[i]) padIn[i] = padOut[i];
      else if (extEn[i]) padIn[i] = extVal[i];
      else if (pullEn[i]) padIn[i] = 1'b1;
      else padIn[i] = noise[i];
    end
  end
endmodule

// File: bench/tb.sv
// self-checking bench for the general-purpose port block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb;
  import gpio_pkg::*;
  localparam int DW = DIGITAL_PORTS*PORT_WIDTH;
  logic          clk = 0, reset_n = 0, resetPin_n = 1, scanEnable = 0, converterEnable = 0;
  logic          pullDisable = 0, analogWrEn = 0, inReset;
  logic [DW-1:0] wrDir = 0, wrOut = 0, wrPull = 0, altEn = 0, altDir = 0, altOut = 0, extEn = 0;
  logic [DW-1:0] digitalPinsIn, digitalPinsOut, digitalPinsOe, digitalPullEn, digitalPinValue;
  logic [3:0]    wrEn = 0;
  logic [7:0]    analogDir = 0, analogOut = 0, analogPull = 0, analog_shared_port_pins_in;
  logic [7:0]    analogPinsOut, analogPinsOe, analogPullEn, analogPinValue;
  int            mismatches = 0, tests_run = 0, cycles = 0;
  initial forever #2 clk = ~clk;
  port_block #(.PULSE_CYCLES(4)) u_port_block (.clk, .reset_n, .resetPin_n, .scanEnable, .converterEnable,
    .pullDisable, .wrDir, .wrOut, .wrPull, .wrEn, .analogDir, .analogOut, .analogPull, .analogWrEn,
    .altEn, .altDir, .altOut, .digitalPinsIn, .digitalPinsOut, .digitalPinsOe, .digitalPullEn,
    .digitalPinValue, .analog_shared_port_pins_in, .analogPinsOut, .analogPinsOe, .analogPullEn,
    .analogPinValue, .inReset);
  board_model #(.W(DW)) u_board_model (.clk, .padOut(digitalPinsOut), .padOe(digitalPinsOe),
    .pullEn(digitalPullEn), .extEn, .extVal('0), .padIn(digitalPinsIn));
  board_model #(.W(8)) u_board_model_a (.clk, .padOut(analogPinsOut), .padOe(analogPinsOe),
    .pullEn(analogPullEn), .extEn('0), .extVal('0), .padIn(analog_shared_port_pins_in));
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_port(int p, logic [7:0] d, logic [7:0] o, logic [7:0] u);
    wrDir[p*8+:8] = d;
    wrOut[p*8+:8] = o;
    wrPull[p*8+:8] = u;
    wrEn[p] = 1;
    tick(1);
    wrEn = 0;
    tick(2);
  endtask
  task automatic wr_analog(logic [7:0] d, logic [7:0] o, logic [7:0] u);
    {analogDir, analogOut, analogPull, analogWrEn} = {d, o, u, 1'b1};
    tick(1);
    analogWrEn = 0;
    tick(2);
  endtask
  task automatic t_reset_state;
    `CHK("oe", '0, digitalPinsOe)
    `CHK("pull", '0, digitalPullEn)
    `CHK("apull", 8'h00, analogPullEn)
    `CHK("inrst", 1'b0, inReset)
    $display("test reset_state done");
  endtask
  task automatic t_dir_out;
    extEn = '1;
    for (int p = 0; p < DIGITAL_PORTS; p++) begin
      wr_port(p, 8'h3c, 8'h5a ^ 8'(p), 8'h00);
      tick(3);
      `CHK("oe", 8'h3c, digitalPinsOe[p*8+:8])
      `CHK("val", (8'h5a ^ 8'(p)) & 8'h3c, digitalPinValue[p*8+:8])
    end
    $display("test dir_out done");
  endtask
  task automatic t_pull;
    extEn = '0;
    for (int p = 0; p < DIGITAL_PORTS; p++) begin
      wr_port(p, 8'h00, 8'h00, 8'h80 | (8'h01 << p));
      `CHK("pull", 8'h80 | (8'h01 << p), digitalPullEn[p*8+:8])
    end
    pullDisable = 1;
    tick(3);
    `CHK("pulloff", '0, digitalPullEn)
    pullDisable = 0;
    $display("test pull done");
  endtask
  task automatic t_alt;
    {altEn, altDir, altOut} = {32'hff, 32'hff, 32'h96};
    tick(3);
    `CHK("altoe", 8'hff, digitalPinsOe[7:0])
    `CHK("altout", 8'h96, digitalPinsOut[7:0])
    altEn = 0;
    tick(3);
    `CHK("portoe", 8'h00, digitalPinsOe[7:0])
    $display("test alt done");
  endtask
  task automatic t_analog;
    wr_analog(8'hff, 8'hc3, 8'h00);
    `CHK("aout", 8'hc3, analogPinsOut)
    tick(2);
    `CHK("ain", 8'hc3, analogPinValue)
    converterEnable = 1;
    tick(5);
    `CHK("aoff", 8'h00, analogPinsOe)
    converterEnable = 0;
    tick(5);
    `CHK("aon", 8'hff, analogPinsOe)
    $display("test analog done");
  endtask
  task automatic t_scan;
    scanEnable = 1;
    tick(5);
    `CHK("scanoe", ~SCAN_PULL_MASK, analogPinsOe)
    `CHK("scanpu", SCAN_PULL_MASK, analogPullEn)
    reset_n = 0;
    tick(2);
    `CHK("rstpu", SCAN_PULL_MASK, analogPullEn)
    `CHK("rstoe", 8'h00, analogPinsOe)
    reset_n = 1;
    scanEnable = 0;
    tick(5);
    `CHK("nopu", 8'h00, analogPullEn)
    $display("test scan done");
  endtask
  task automatic t_pin_reset;
    wr_port(0, 8'hff, 8'h00, 8'h00);
    resetPin_n = 0;
    tick(1);
    `CHK("tri", '0, digitalPinsOe)
    `CHK("inrst", 1'b1, inReset)
    resetPin_n = 1;
    tick(8);
    `CHK("short", 8'hff, digitalPinsOe[7:0])
    resetPin_n = 0;
    tick(10);
    resetPin_n = 1;
    tick(8);
    `CHK("long", 8'h00, digitalPinsOe[7:0])
    $display("test pin_reset done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ceiling is well above the roughly 116 cycles the tests take
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    tick(12);
    reset_n = 1;
    tick(2);
    t_reset_state();
    t_dir_out();
    t_pull();
    t_alt();
    t_analog();
    t_scan();
    t_pin_reset();
    complete_run();
  end
endmodule

// File: logic/port_block.sv
// general-purpose port block: four digital ports and one analogue-shared port
`timescale 1ns/1ps
// How it works
// - every port has eight pins, each separately an input or an output.
// - each pin has its own software pull-up enable.
// - any active reset tri-states all pins on the next clock edge, as the pad controls are registered.
// - an enabled peripheral function overrides the plain port control of a pin.
// - analogue-shared port is a digital port only while the converter is idle.
// - scan interface enabled keeps pull-ups on analogue bits 7, 5, 4, even in reset.
// - reset pin low longer than the minimum pulse resets the device; the filter counts clock cycles.
module port_block
  import gpio_pkg::*;
#(
  parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
) (
  input  wire logic                                 clk,
  input  wire logic                                 reset_n,
  input  wire logic                                 resetPin_n,
  input  wire logic                                 scanEnable,
  input  wire logic                                 converterEnable,
  input  wire logic                                 pullDisable,
  input  wire logic [DIGITAL_PORTS*PORT_WIDTH-1:0]  wrDir,
  input  wire logic [DIGITAL_PORTS*PORT_WIDTH-1:0]  wrOut,
  input  wire logic [DIGITAL_PORTS*PORT_WIDTH-1:0]  wrPull,
  input  wire logic [DIGITAL_PORTS-1:0]             wrEn,
  input  wire logic [PORT_WIDTH-1:0]                analogDir,
  input  wire logic [PORT_WIDTH-1:0]                analogOut,
  input  wire logic [PORT_WIDTH-1:0]                analogPull,
  input  wire logic                                 analogWrEn,
  input  wire logic [DIGITAL_PORTS*PORT_WIDTH-1:0]  altEn,
  input  wire logic [DIGITAL_PORTS*PORT_WIDTH-1:0]  altDir,
  input  wire logic [DIGITAL_PORTS*PORT_WIDTH-1:0]  altOut,
  input  wire logic [DIGITAL_PORTS*PORT_WIDTH-1:0]  digitalPinsIn,
  output logic      [DIGITAL_PORTS*PORT_WIDTH-1:0]  digitalPinsOut,
  output logic      [DIGITAL_PORTS*PORT_WIDTH-1:0]  digitalPinsOe,
  output logic      [DIGITAL_PORTS*PORT_WIDTH-1:0]  digitalPullEn,
  output logic      [DIGITAL_PORTS*PORT_WIDTH-1:0]  digitalPinValue,
  input  wire logic [PORT_WIDTH-1:0]                analog_shared_port_pins_in,
  output logic      [PORT_WIDTH-1:0]                analogPinsOut,
  output logic      [PORT_WIDTH-1:0]                analogPinsOe,
  output logic      [PORT_WIDTH-1:0]                analogPullEn,
  output logic      [PORT_WIDTH-1:0]                analogPinValue,
  output logic                                      inReset
);
  localparam int CW = $clog2(PULSE_CYCLES + 1);

  logic [DIGITAL_PORTS*PORT_WIDTH-1:0] dir;
  logic [DIGITAL_PORTS*PORT_WIDTH-1:0] outVal;
  logic [DIGITAL_PORTS*PORT_WIDTH-1:0] pull;
  logic [PORT_WIDTH-1:0]               aDir;
  logic [PORT_WIDTH-1:0]               aOut;
  logic [PORT_WIDTH-1:0]               aPull;
  logic                                pinSyncA;
  logic                                pinSyncB;
  logic [CW-1:0]                       lowCount;
  logic                                pinReset;
  logic                                scanSyncA;
  logic                                scanSync;
  logic                                convSyncA;
  logic                                convSync;
  logic [PORT_WIDTH-1:0]               scanPull;
  logic [PORT_WIDTH-1:0]               analogBlock;
  logic                                holdReset;
  logic                                cfgReset;

  initial begin
    if (PULSE_CYCLES < 1) $error("reset pulse must last at least one cycle");
  end

  // reset pin qualified by a filter; short glitches do not reset
  always_ff @(posedge clk) begin
    pinSyncA <= resetPin_n;
    pinSyncB <= pinSyncA;
  end

  always_ff @(posedge clk) begin
    if (pinSyncB) begin
      lowCount <= '0;
      pinReset <= 1'b0;
    end else if (lowCount >= CW'(PULSE_CYCLES - 1)) begin
      pinReset <= 1'b1;
    end else begin
      lowCount <= lowCount + CW'(1);
    end
  end

  // the raw pin low also tri-states without the filter, but the registered pad controls float the pads only on a clock edge
  assign holdReset = ~reset_n | pinReset | ~resetPin_n;
  // only a qualified reset clears the configuration; a short glitch merely floats the pads
  assign cfgReset  = ~reset_n | pinReset;

  always_ff @(posedge clk) begin
    inReset <= holdReset;
  end

  always_ff @(posedge clk) begin
    scanSyncA <= scanEnable;
    scanSync  <= scanSyncA;
    convSyncA <= converterEnable;
    convSync  <= convSyncA;
  end

  always_ff @(posedge clk) begin
    if (cfgReset) begin
      dir    <= {DIGITAL_PORTS{DIR_RESET}};
      outVal <= {DIGITAL_PORTS{OUT_RESET}};
      pull   <= {DIGITAL_PORTS{PULL_RESET}};
    end else begin
      for (int p = 0; p < DIGITAL_PORTS; p++) begin
        if (wrEn[p]) begin
          dir[p*PORT_WIDTH +: PORT_WIDTH]    <= wrDir[p*PORT_WIDTH +: PORT_WIDTH];
          outVal[p*PORT_WIDTH +: PORT_WIDTH] <= wrOut[p*PORT_WIDTH +: PORT_WIDTH];
          pull[p*PORT_WIDTH +: PORT_WIDTH]   <= wrPull[p*PORT_WIDTH +: PORT_WIDTH];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (cfgReset) begin
      aDir  <= DIR_RESET;
      aOut  <= OUT_RESET;
      aPull <= PULL_RESET;
    end else if (analogWrEn) begin
      aDir  <= analogDir;
      aOut  <= analogOut;
      aPull <= analogPull;
    end
  end

  // scan pins keep pull-ups regardless of reset; converter blocks digital use
  assign scanPull    = scanSync ? SCAN_PULL_MASK : '0;
  assign analogBlock = convSync ? '1 : (scanSync ? SCAN_PULL_MASK : '0);

  logic [DIGITAL_PORTS*PORT_WIDTH-1:0] dOut;
  logic [DIGITAL_PORTS*PORT_WIDTH-1:0] dOe;
  logic [DIGITAL_PORTS*PORT_WIDTH-1:0] dPull;
  logic [PORT_WIDTH-1:0]               fOut;
  logic [PORT_WIDTH-1:0]               fOe;
  logic [PORT_WIDTH-1:0]               fPull;

  for (genvar g = 0; g < DIGITAL_PORTS; g++) begin : g_port
    port_slice #(.WIDTH(PORT_WIDTH)) u_port (
      .clk         (clk),
      .inReset     (holdReset),
      .swDir       (dir[g*PORT_WIDTH +: PORT_WIDTH]),
      .swOut       (outVal[g*PORT_WIDTH +: PORT_WIDTH]),
      .swPull      (pull[g*PORT_WIDTH +: PORT_WIDTH]),
      .pullDisable (pullDisable),
      .altEn       (altEn[g*PORT_WIDTH +: PORT_WIDTH]),
      .altDir      (altDir[g*PORT_WIDTH +: PORT_WIDTH]),
      .altOut      (altOut[g*PORT_WIDTH +: PORT_WIDTH]),
      .blockMask   ('0),
      .forcePull   ('0),
      .padIn       (digitalPinsIn[g*PORT_WIDTH +: PORT_WIDTH]),
      .padOut      (dOut[g*PORT_WIDTH +: PORT_WIDTH]),
      .padOe       (dOe[g*PORT_WIDTH +: PORT_WIDTH]),
      .pullEn      (dPull[g*PORT_WIDTH +: PORT_WIDTH]),
      .pinValue    (digitalPinValue[g*PORT_WIDTH +: PORT_WIDTH])
    );
  end

  port_slice #(.WIDTH(PORT_WIDTH)) u_analog (
    .clk         (clk),
    .inReset     (holdReset),
    .swDir       (aDir),
    .swOut       (aOut),
    .swPull      (aPull),
    .pullDisable (pullDisable),
    .altEn       ('0),
    .altDir      ('0),
    .altOut      ('0),
    .blockMask   (analogBlock),
    .forcePull   (scanPull),
    .padIn       (analog_shared_port_pins_in),
    .padOut      (fOut),
    .padOe       (fOe),
    .pullEn      (fPull),
    .pinValue    (analogPinValue)
  );

  // registered pad controls: one cycle behind, trade for clean flop outputs
  always_ff @(posedge clk) begin
    digitalPinsOut <= dOut;
    digitalPinsOe  <= dOe;
    digitalPullEn  <= dPull;
    analogPinsOut  <= fOut;
    analogPinsOe   <= fOe;
    analogPullEn   <= fPull;
  end


  chk_reset_floats: assert property (@(posedge clk)
    holdReset |=> (digitalPinsOe == '0 && analogPinsOe == '0))
    else $error("pins driven during reset");
  chk_status_flag: assert property (@(posedge clk)
    holdReset |=> inReset)
    else $error("reset status not raised");
  chk_scan_pulls: assert property (@(posedge clk) disable iff (!reset_n)
    $past(scanSync) |-> (analogPullEn & SCAN_PULL_MASK) == SCAN_PULL_MASK)
    else $error("scan pull-ups missing");
  chk_scan_no_drive: assert property (@(posedge clk) disable iff (!reset_n)
    $past(scanSync) |-> (analogPinsOe & SCAN_PULL_MASK) == '0)
    else $error("scan pin driven while scan on");
  chk_conv_blocks: assert property (@(posedge clk) disable iff (!reset_n)
    $past(convSync) |-> analogPinsOe == '0)
    else $error("analogue pin driven while converter on");
  chk_alt_override: assert property (@(posedge clk) disable iff (holdReset)
    (dOe & altEn) == (altDir & altEn))
    else $error("peripheral direction not applied");
  chk_pull_input: assert property (@(posedge clk) disable iff (holdReset)
    (dPull & dOe) == '0)
    else $error("pull-up on a driven pin");
  chk_pin_filter: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(pinReset) |-> $past(!pinSyncB, 1))
    else $error("pin reset without low level");
  // configuration must read as all inputs with pull-ups off once a qualified reset ends
  sequence cfgReleased;
    $fell(cfgReset);
  endsequence
  sequence portsIdle;
    dir == '0 && pull == '0 && aDir == '0 && aPull == '0;
  endsequence
  chk_boot_inputs: assert property (@(posedge clk) disable iff (!reset_n)
    cfgReleased |-> portsIdle)
    else $error("port not input after reset");
endmodule

// File: logic/port_slice.sv
// one 8-bit bidirectional port with pull-up, override and tri-state on reset
`timescale 1ns/1ps
module port_slice
  import gpio_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  input  wire logic             clk,
  input  wire logic             inReset,
  input  wire logic [WIDTH-1:0] swDir,
  input  wire logic [WIDTH-1:0] swOut,
  input  wire logic [WIDTH-1:0] swPull,
  input  wire logic             pullDisable,
  input  wire logic [WIDTH-1:0] altEn,
  input  wire logic [WIDTH-1:0] altDir,
  input  wire logic [WIDTH-1:0] altOut,
  input  wire logic [WIDTH-1:0] blockMask,
  input  wire logic [WIDTH-1:0] forcePull,
  input  wire logic [WIDTH-1:0] padIn,
  output logic      [WIDTH-1:0] padOut,
  output logic      [WIDTH-1:0] padOe,
  output logic      [WIDTH-1:0] pullEn,
  output logic      [WIDTH-1:0] pinValue
);
  logic [WIDTH-1:0] syncA;
  logic [WIDTH-1:0] syncB;
  logic [WIDTH-1:0] next_oe;
  logic [WIDTH-1:0] next_out;

  initial begin
    if (WIDTH < 1) $error("port width must be positive");
  end

  always_comb begin
    next_oe  = (altEn & altDir) | (~altEn & swDir);
    next_oe  = next_oe & ~blockMask;
    next_out = (altEn & altOut) | (~altEn & swOut);
  end

  // enables other than forced pull-ups drop straight from the reset level, no clock edge needed
  always_comb begin
    padOe  = inReset ? '0 : next_oe;
    padOut = inReset ? '0 : next_out;
    pullEn = (inReset ? '0 : (swPull & ~next_oe & ~blockMask
             & {WIDTH{~pullDisable}})) | forcePull;
  end

  always_ff @(posedge clk) begin
    syncA    <= padIn;
    syncB    <= syncA;
    pinValue <= syncB;
  end
endmodule

// File: shared/gpio_pkg.sv
// constants for the general-purpose port block
package gpio_pkg;
  localparam int PORT_WIDTH         = 8;
  localparam int DIGITAL_PORTS      = 4;
  localparam int SCAN_TDI_BIT       = 7;
  localparam int SCAN_TMS_BIT       = 5;
  localparam int SCAN_TCK_BIT       = 4;
  localparam logic [7:0] SCAN_PULL_MASK = 8'hb0;
  localparam logic [7:0] DIR_RESET  = 8'h00;
  localparam logic [7:0] PULL_RESET = 8'h00;
  localparam logic [7:0] OUT_RESET  = 8'h00;
  // minimum external reset pulse, in ns, and its length in cycles
  localparam int RESET_PULSE_NS     = 2500;
  localparam int CLK_PERIOD_PS      = 4000;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage
